// ---- slio_port.sv ----
// Purpose: Four-channel programmable line I/O port with chopper clock
// Assumes: All pin inputs synchronous to clk; commands pre-deframed
// Notes:   Hardware reset from chip select clears all settings

`timescale 1ns/1ns

module slio_port #(
  parameter int MS_CYCLES      = slio_pkg::MS_CYCLES,
  parameter int E1_HALF_CYCLES = slio_pkg::E1_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Host command port
  input  wire logic                cs_n,
  input  wire logic                host_serial_clock,
  input  wire slio_pkg::slio_cmd_t cmd,
  output logic                     rsp_valid,
  output logic [7:0]               rsp_data,
  // Line interface circuit pins
  input  wire slio_pkg::slio_pins_t [3:0] line_i,
  output slio_pkg::slio_pins_t [3:0]      line_o,
  output slio_pkg::slio_pins_t [3:0]      line_oe,
  // Mode and status
  input  wire logic                pcm_clock_mode,
  input  wire logic                mux_mode_en,
  input  wire logic                chopper_fast_sel,
  input  wire logic [7:0]          int_mask,
  output logic                     regulator_switch_clock,
  output logic                     detector_mux_strobe,
  output logic                     detector_mux_strobe_oe,
  output logic                     int_n
);

  // ----------------------------------------------------------------
  // Chip select tracking and hardware reset
  // ----------------------------------------------------------------
  slio_pkg::slio_cs_t cs_st_q;
  logic [3:0]         host_serial_clock_cnt_q;
  logic               sck_q;
  logic               hw_rst_q;

  wire srst      = !rst_n || hw_rst_q;
  wire host_serial_clock_rise = host_serial_clock && !sck_q;
  wire host_serial_clock_last = host_serial_clock_rise && (host_serial_clock_cnt_q == 4'(slio_pkg::HW_RST_EDGES - 1));
  wire hw_rst_d  = cs_n && (cs_st_q == slio_pkg::CS_ARMED);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_q    <= 1'b0;
      hw_rst_q <= 1'b0;
    end else begin
      sck_q    <= host_serial_clock;
      hw_rst_q <= hw_rst_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cs_st_q    <= slio_pkg::CS_IDLE;
      host_serial_clock_cnt_q <= 4'h0;
    end else begin
      unique case (cs_st_q)
        slio_pkg::CS_IDLE: begin
          // A clock rise in the select cycle itself counts too
          host_serial_clock_cnt_q <= (!cs_n && host_serial_clock_rise) ? 4'h1 : 4'h0;
          if (!cs_n) cs_st_q <= slio_pkg::CS_SEL;
        end
        slio_pkg::CS_SEL: begin
          if (cs_n) begin
            cs_st_q <= slio_pkg::CS_IDLE;
          end else if (host_serial_clock_last) begin
            cs_st_q <= slio_pkg::CS_ARMED;
          end else if (host_serial_clock_rise) begin
            host_serial_clock_cnt_q <= host_serial_clock_cnt_q + 4'h1;
          end
        end
        slio_pkg::CS_ARMED: begin
          if (cs_n) cs_st_q <= slio_pkg::CS_IDLE;
        end
        default: cs_st_q <= slio_pkg::CS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic [3:0]                   ch_en_q;
  logic [3:0][4:0]              dir_q;
  logic [3:0][4:0]              out_q;
  logic [3:0][3:0]              deb_q;
  logic [3:0][3:0]              samp_q;
  logic [3:0]                   a_f;
  logic [3:0]                   b_f;

  wire cmd_ok  = cmd.valid && !cs_n && !srst;
  wire wr_en   = cmd_ok && (cmd.op == slio_pkg::OP_CH_EN);
  wire wr_out  = cmd_ok && (cmd.op == slio_pkg::OP_WR_OUT);
  wire wr_dir  = cmd_ok && (cmd.op == slio_pkg::OP_WR_DIR);
  wire wr_deb  = cmd_ok && (cmd.op == slio_pkg::OP_DEB);
  wire wr_samp = cmd_ok && (cmd.op == slio_pkg::OP_SAMP);
  wire rd_rt   = cmd_ok && (cmd.op == slio_pkg::OP_RD_RT1 || cmd.op == slio_pkg::OP_RD_RT2);
  wire rd_ch   = cmd_ok && (cmd.op == slio_pkg::OP_RD_CH);

  // Lowest enabled channel answers a per-channel read
  wire [1:0] ch_sel = ch_en_q[0] ? 2'h0 : ch_en_q[1] ? 2'h1 : ch_en_q[2] ? 2'h2 : 2'h3;
  wire       ch_any = |ch_en_q;
  wire slio_pkg::slio_pins_t sel_pins = line_i[ch_sel];
  wire [7:0] ch_word = {3'h0, sel_pins.e, sel_pins.d, sel_pins.c, b_f[ch_sel], a_f[ch_sel]};
  wire [7:0] rt_word = {b_f, a_f};

  always_ff @(posedge clk) begin
    if (srst) begin
      ch_en_q <= slio_pkg::RST_EN;
    end else if (wr_en) begin
      ch_en_q <= cmd.data[slio_pkg::EN_LSB +: slio_pkg::NUM_CH];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
    end else begin
      rsp_valid <= rd_rt || rd_ch;
      if (rd_rt) begin
        rsp_data <= rt_word;
      end else if (rd_ch) begin
        rsp_data <= ch_any ? ch_word : 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Millisecond tick and detector strobe
  // ----------------------------------------------------------------
  logic [17:0] ms_cnt_q;
  logic [14:0] e1_cnt_q;
  logic        ms_tick_q;
  logic [3:0]  hook_q;
  logic [3:0]  gkey_q;

  wire ms_wrap = ms_cnt_q == 18'(MS_CYCLES - 1);
  wire e1_wrap = e1_cnt_q == 15'(E1_HALF_CYCLES - 1);
  wire mux_act = mux_mode_en && pcm_clock_mode;

  always_ff @(posedge clk) begin
    if (srst) begin
      ms_cnt_q  <= 18'h00000;
      ms_tick_q <= 1'b0;
    end else begin
      ms_cnt_q  <= ms_wrap ? 18'h00000 : ms_cnt_q + 18'h00001;
      ms_tick_q <= ms_wrap;
    end
  end

  // Strobe phase high samples hook, low samples ground key
  always_ff @(posedge clk) begin
    if (srst) begin
      e1_cnt_q               <= 15'h0000;
      detector_mux_strobe    <= 1'b0;
      detector_mux_strobe_oe <= 1'b0;
    end else begin
      detector_mux_strobe_oe <= pcm_clock_mode;
      if (!pcm_clock_mode) begin
        e1_cnt_q            <= 15'h0000;
        detector_mux_strobe <= 1'b0;
      end else if (e1_wrap) begin
        e1_cnt_q            <= 15'h0000;
        detector_mux_strobe <= !detector_mux_strobe;
      end else begin
        e1_cnt_q <= e1_cnt_q + 15'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-channel pins, demux and filters
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < slio_pkg::NUM_CH; g++) begin : g_ch
      wire en_g = ch_en_q[g];
      wire raw_a = mux_act ? hook_q[g] : line_i[g].a;
      wire raw_b = mux_act ? gkey_q[g] : line_i[g].b;

      always_ff @(posedge clk) begin
        if (srst) begin
          dir_q[g]  <= slio_pkg::RST_DIR;
          out_q[g]  <= slio_pkg::RST_OUT;
          deb_q[g]  <= slio_pkg::RST_TIME;
          samp_q[g] <= slio_pkg::RST_TIME;
        end else if (en_g) begin
          if (wr_dir) dir_q[g] <= cmd.data[slio_pkg::PIN_W-1:0];
          if (wr_out) out_q[g] <= cmd.data[slio_pkg::PIN_W-1:0];
          if (wr_deb) deb_q[g] <= cmd.data[slio_pkg::TIME_W-1:0];
          if (wr_samp) samp_q[g] <= cmd.data[slio_pkg::TIME_W-1:0];
        end
      end

      always_ff @(posedge clk) begin
        if (srst) begin
          hook_q[g] <= 1'b0;
          gkey_q[g] <= 1'b0;
        end else if (mux_act && e1_wrap) begin
          if (detector_mux_strobe) hook_q[g] <= line_i[g].a;
          else gkey_q[g] <= line_i[g].a;
        end
      end

      always_ff @(posedge clk) begin
        if (srst) begin
          line_o[g]  <= '0;
          line_oe[g] <= '0;
        end else begin
          line_o[g]  <= out_q[g];
          line_oe[g] <= dir_q[g];
        end
      end

      slio_filt u_filt (
        .clk     (clk),
        .srst    (srst),
        .ms_tick (ms_tick_q),
        .deb_ms  (deb_q[g]),
        .samp_ms (samp_q[g]),
        .raw_a   (raw_a),
        .raw_b   (raw_b),
        .a_q     (a_f[g]),
        .b_q     (b_f[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Chopper clock: free-running divider, phase arbitrary
  // ----------------------------------------------------------------
  logic [8:0] chop_cnt_q;
  wire [8:0] chop_half = chopper_fast_sel ? 9'(slio_pkg::CHOP_FAST_HALF - 1)
                                          : 9'(slio_pkg::CHOP_SLOW_HALF - 1);

  always_ff @(posedge clk) begin
    if (srst) begin
      chop_cnt_q             <= 9'h000;
      regulator_switch_clock <= 1'b0;
    end else if (chop_cnt_q == 9'h000) begin
      chop_cnt_q             <= chop_half;
      regulator_switch_clock <= !regulator_switch_clock;
    end else begin
      chop_cnt_q <= chop_cnt_q - 9'h001;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt on real-time bit change; set beats read clear
  // ----------------------------------------------------------------
  logic [7:0] rt_q;
  wire        rt_chg = |((rt_word ^ rt_q) & ~int_mask);

  always_ff @(posedge clk) begin
    if (srst) begin
      rt_q  <= 8'h00;
      int_n <= 1'b1;
    end else begin
      rt_q  <= rt_word;
      int_n <= !(rt_chg || (!int_n && !rd_rt));
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_rd_grp;
    cmd.valid && !cs_n && (cmd.op == slio_pkg::OP_RD_RT1 || cmd.op == slio_pkg::OP_RD_RT2);
  endsequence

  a_cmd_gated: assert property (cmd.valid && cs_n |=> $stable(dir_q) && $stable(out_q))
    else $error("command taken while chip select high");
  a_out_write: assert property (wr_out && ch_en_q[0] |=> out_q[0] == $past(cmd.data[4:0]))
    else $error("output write not loaded");
  a_out_enable: assert property (wr_out && !ch_en_q[3] |=> $stable(out_q[3]))
    else $error("disabled channel changed");
  a_out_hold: assert property (!wr_out |=> $stable(out_q))
    else $error("output level changed without write");
  a_dir_write: assert property (wr_dir && ch_en_q[1] |=> ##1 line_oe[1] == $past(cmd.data[4:0], 2))
    else $error("direction not applied to pins");
  a_rd_group: assert property (s_rd_grp |=> rsp_valid && rsp_data == $past(rt_word))
    else $error("group read data wrong");
  a_rd_chan: assert property (rd_ch && ch_en_q[0] |=> rsp_data[1:0] == $past({b_f[0], a_f[0]}))
    else $error("channel read data wrong");
  a_chop_hold: assert property (chop_cnt_q != 9'h000 |=> $stable(regulator_switch_clock))
    else $error("chopper toggled early");
  // Own disable: the pulse under test is itself part of srst
  a_hw_reset: assert property (disable iff (!rst_n) hw_rst_d |=> hw_rst_q)
    else $error("hardware reset not raised");
  a_int_raise: assert property (rt_chg |=> !int_n)
    else $error("interrupt not raised on change");

endmodule

// ---- slio_pkg.sv ----
// Purpose: Shared constants and types for the line I/O port block
// Assumes: 250 MHz clk, host commands arrive already deframed
// Notes:   Opcodes are decimal command numbers written in hex

package slio_pkg;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int NUM_CH       = 4;
  localparam int CLK_HZ       = 250_000_000;
  localparam int DEB_STEP_MS  = 1;
  localparam int MS_CYCLES    = CLK_HZ / 1000 * DEB_STEP_MS;
  localparam int CHOP_SLOW_HZ = 256_000;
  localparam int CHOP_FAST_10HZ = 29_257;
  localparam int CHOP_SLOW_HALF = CLK_HZ / (2 * CHOP_SLOW_HZ);
  localparam int CHOP_FAST_HALF = CLK_HZ / (2 * CHOP_FAST_10HZ * 10);
  localparam int E1_HALF_US   = 125;
  localparam int E1_HALF_CYCLES = CLK_HZ / 1_000_000 * E1_HALF_US;
  localparam int HW_RST_EDGES = 16;
  localparam int UD_MAX       = 3;

  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_CH_EN  = 8'h0E;
  localparam logic [7:0] OP_RD_RT1 = 8'h10;
  localparam logic [7:0] OP_RD_RT2 = 8'h11;
  localparam logic [7:0] OP_WR_OUT = 8'h14;
  localparam logic [7:0] OP_RD_CH  = 8'h15;
  localparam logic [7:0] OP_WR_DIR = 8'h16;
  localparam logic [7:0] OP_DEB    = 8'h2D;
  localparam logic [7:0] OP_SAMP   = 8'h34;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int PIN_W = 5;
  localparam int TIME_W = 4;
  localparam int EN_LSB = 0;
  localparam logic [4:0] RST_DIR  = 5'h00;
  localparam logic [4:0] RST_OUT  = 5'h00;
  localparam logic [3:0] RST_TIME = 4'h0;
  localparam logic [3:0] RST_EN   = 4'h0;

  typedef struct packed {
    logic e;
    logic d;
    logic c;
    logic b;
    logic a;
  } slio_pins_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] op;
    logic [7:0] data;
  } slio_cmd_t;

  typedef enum logic [2:0] {
    CS_IDLE  = 3'b001,
    CS_SEL   = 3'b010,
    CS_ARMED = 3'b100
  } slio_cs_t;

endpackage

// ---- slio_filt.sv ----
// Purpose: Debounce of first input and up/down filter of second input
// Assumes: ms_tick is a one-cycle pulse each millisecond
// Notes:   Zero time passes the raw level straight through

`timescale 1ns/1ns

module slio_filt (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ms_tick,
  // Settings
  input  wire logic [3:0] deb_ms,
  input  wire logic [3:0] samp_ms,
  // Raw and filtered bits
  input  wire logic       raw_a,
  input  wire logic       raw_b,
  output logic            a_q,
  output logic            b_q
);

  logic [3:0] deb_cnt_q;
  logic [3:0] samp_cnt_q;
  logic [1:0] ud_q;

  wire       a_diff   = raw_a != a_q;
  wire [3:0] deb_next = deb_cnt_q + 4'h1;
  // One tick beyond the count: the first tick may fall mid-millisecond
  wire       deb_done = ms_tick && (deb_cnt_q == deb_ms);
  wire [3:0] samp_next = samp_cnt_q + 4'h1;
  wire       sample   = ms_tick && (samp_next >= samp_ms);
  wire [1:0] ud_up    = (ud_q == 2'(slio_pkg::UD_MAX)) ? ud_q : ud_q + 2'h1;
  wire [1:0] ud_dn    = (ud_q == 2'h0) ? ud_q : ud_q - 2'h1;
  wire [1:0] ud_new   = raw_b ? ud_up : ud_dn;

  // ----------------------------------------------------------------
  // Debounce: counter restarts whenever raw agrees again
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      deb_cnt_q <= slio_pkg::RST_TIME;
      a_q       <= 1'b0;
    end else if (!a_diff) begin
      deb_cnt_q <= 4'h0;
    end else if (deb_ms == 4'h0) begin
      a_q <= raw_a;
    end else if (deb_done) begin
      a_q       <= raw_a;
      deb_cnt_q <= 4'h0;
    end else if (ms_tick) begin
      deb_cnt_q <= deb_next;
    end
  end

  // ----------------------------------------------------------------
  // Up/down counter filter, output flips only at the rails
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      samp_cnt_q <= slio_pkg::RST_TIME;
      ud_q       <= 2'h0;
      b_q        <= 1'b0;
    end else if (samp_ms == 4'h0) begin
      b_q <= raw_b;
    end else if (sample) begin
      samp_cnt_q <= 4'h0;
      ud_q       <= ud_new;
      if (ud_new == 2'(slio_pkg::UD_MAX)) begin
        b_q <= 1'b1;
      end else if (ud_new == 2'h0) begin
        b_q <= 1'b0;
      end
    end else if (ms_tick) begin
      samp_cnt_q <= samp_next;
    end
  end

endmodule

// ---- slio_line_model.sv ----
// Purpose: Line interface circuit model facing the port pins
// Assumes: A pin driven by the port reads straight back as its input
// Notes:   Hook and ground-key share pin a while the strobe pin is driven

`timescale 1ns/1ns

module slio_line_model (
  // Port side
  input  wire slio_pkg::slio_pins_t [3:0] line_o,
  input  wire slio_pkg::slio_pins_t [3:0] line_oe,
  input  wire logic                       strobe,
  input  wire logic                       strobe_oe,
  // Line state set by the bench
  input  wire slio_pkg::slio_pins_t [3:0] level,
  input  wire logic [3:0]                 hook,
  input  wire logic [3:0]                 gkey,
  output slio_pkg::slio_pins_t [3:0]      line_i
);
  for (genvar ch = 0; ch < 4; ch++) begin : g_ch
    // Detector answers on pin a by strobe phase, high half is hook
    wire logic a_src = strobe_oe ? (strobe ? hook[ch] : gkey[ch]) : level[ch].a;
    wire logic [4:0] own = {level[ch][4:1], a_src};
    assign line_i[ch] = (line_oe[ch] & line_o[ch]) | (~line_oe[ch] & own);
  end
endmodule

// ---- test_slio_port.sv ----
// Purpose: Self-checking bench for the line I/O port
// Assumes: Short millisecond and strobe counts set by parameter
// Notes:   Reads are checked from a queue by a separate monitor

`timescale 1ns/1ns

module test_slio_port;
  localparam int MSC = 20;
  localparam int E1H = 8;
  logic                       clk = 1'b0;
  logic                       rst_n = 1'b0;
  logic                       cs_n = 1'b0;
  logic                       host_serial_clock = 1'b0;
  slio_pkg::slio_cmd_t        cmd = '0;
  logic                       rsp_valid;
  logic [7:0]                 rsp_data;
  slio_pkg::slio_pins_t [3:0] line_i;
  slio_pkg::slio_pins_t [3:0] line_o;
  slio_pkg::slio_pins_t [3:0] line_oe;
  slio_pkg::slio_pins_t [3:0] level = '0;
  logic [3:0]                 hook = 4'h5;
  logic [3:0]                 gkey = 4'h3;
  logic                       pcm_clock_mode = 1'b0;
  logic                       mux_mode_en = 1'b0;
  logic                       chopper_fast_sel = 1'b0;
  logic [7:0]                 int_mask = 8'h00;
  logic                       regulator_switch_clock;
  logic                       detector_mux_strobe;
  logic                       detector_mux_strobe_oe;
  logic                       int_n;
  int                         bad_count = 0;
  int                         checks = 0;
  logic [7:0]                 exp_q[$];
  logic [31:0]                rng = 32'h0000_7F74;

  always #2 clk = ~clk;

  slio_port #(.MS_CYCLES(MSC), .E1_HALF_CYCLES(E1H)) u_slio_port (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .host_serial_clock(host_serial_clock),
    .cmd(cmd), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .line_i(line_i),
    .line_o(line_o), .line_oe(line_oe), .pcm_clock_mode(pcm_clock_mode),
    .mux_mode_en(mux_mode_en), .chopper_fast_sel(chopper_fast_sel), .int_mask(int_mask),
    .regulator_switch_clock(regulator_switch_clock), .detector_mux_strobe(detector_mux_strobe),
    .detector_mux_strobe_oe(detector_mux_strobe_oe), .int_n(int_n));

  slio_line_model u_slio_line_model (
    .line_o(line_o), .line_oe(line_oe), .strobe(detector_mux_strobe),
    .strobe_oe(detector_mux_strobe_oe), .level(level), .hook(hook), .gkey(gkey),
    .line_i(line_i));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] nxt();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[4:0];
  endfunction

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_rsp(input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED rsp_data expected %h seen %h", exp, got);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic send(input logic [7:0] op, input logic [7:0] data);
    @(negedge clk);
    cmd <= '{1'b1, op, data};
    @(negedge clk);
    cmd.valid <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] op, input logic [7:0] exp);
    exp_q.push_back(exp);
    send(op, 8'h00);
  endtask

  // Empty queue yields unknown, so a stray answer is a mismatch
  always @(negedge clk) begin
    if (rsp_valid === 1'b1) begin
      chk_rsp(exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, rsp_data);
    end
  end

  initial begin
    #200000;
    bad_count++;
    $display("Watchdog expired");
    conclude();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [4:0] r;
    logic [4:0] p;
    logic [3:0] av;
    logic [3:0] bv;
    time        t0;
    int         n;
    wait_cyc(10);
    rst_n <= 1'b1;
    wait_cyc(1);
    chk("line_oe reset", 9'h000, line_oe[0]);
    chk("int_n reset", 9'h001, int_n);
    r = nxt();
    send(slio_pkg::OP_CH_EN, 8'h05);
    send(slio_pkg::OP_WR_DIR, 8'h1F);
    send(slio_pkg::OP_WR_OUT, {3'h0, r});
    wait_cyc(50);
    for (n = 0; n < 4; n++) begin
      chk("line_oe", n[0] ? 9'h000 : 9'h01F, line_oe[n]);
      chk("line_o", n[0] ? 9'h000 : {4'h0, r}, line_o[n]);
    end
    cs_n <= 1'b1;
    send(slio_pkg::OP_WR_OUT, {3'h0, ~r});
    cs_n <= 1'b0;
    wait_cyc(4);
    chk("line_o deselected", {4'h0, r}, line_o[0]);
    p = nxt();
    level[0] <= p;
    av = {3'h0, p[0]};
    bv = {3'h0, p[1]};
    send(slio_pkg::OP_WR_DIR, 8'h00);
    send(slio_pkg::OP_DEB, 8'h00);
    send(slio_pkg::OP_SAMP, 8'h00);
    wait_cyc(10);
    rd(slio_pkg::OP_RD_CH, {3'h0, p});
    rd(slio_pkg::OP_RD_RT1, {bv, av});
    rd(slio_pkg::OP_RD_RT2, {bv, av});
    send(slio_pkg::OP_CH_EN, 8'h00);
    rd(slio_pkg::OP_RD_CH, 8'h00);
    send(slio_pkg::OP_CH_EN, 8'h0F);
    wait_cyc(4);
    chk("int_n cleared", 9'h001, int_n);
    level[1].a <= 1'b1;
    av[1] = 1'b1;
    wait_cyc(6);
    chk("int_n change", 9'h000, int_n);
    rd(slio_pkg::OP_RD_RT1, {bv, av});
    wait_cyc(4);
    chk("int_n read", 9'h001, int_n);
    int_mask <= 8'h02;
    level[1].a <= 1'b0;
    av[1] = 1'b0;
    wait_cyc(6);
    chk("int_n masked", 9'h001, int_n);
    // Two ms debounce: the early read falls before two whole ms have passed
    send(slio_pkg::OP_DEB, 8'h02);
    level[3].a <= 1'b1;
    wait_cyc(35);
    rd(slio_pkg::OP_RD_RT1, {bv, av});
    av[3] = 1'b1;
    wait_cyc(60);
    rd(slio_pkg::OP_RD_RT1, {bv, av});
    // Counter needs three samples upward before the bit turns
    send(slio_pkg::OP_SAMP, 8'h01);
    level[3].b <= 1'b1;
    wait_cyc(25);
    rd(slio_pkg::OP_RD_RT2, {bv, av});
    bv[3] = 1'b1;
    wait_cyc(60);
    rd(slio_pkg::OP_RD_RT2, {bv, av});
    pcm_clock_mode <= 1'b1;
    mux_mode_en <= 1'b1;
    wait_cyc(200);
    chk("strobe_oe", 9'h001, detector_mux_strobe_oe);
    @(detector_mux_strobe);
    t0 = $time;
    @(detector_mux_strobe);
    chk("strobe half", 9'(E1H), 9'(($time - t0) / 4));
    rd(slio_pkg::OP_RD_RT1, {gkey, hook});
    pcm_clock_mode <= 1'b0;
    mux_mode_en <= 1'b0;
    for (n = 0; n < 2; n++) begin
      chopper_fast_sel <= n[0];
      repeat (2) @(regulator_switch_clock);
      repeat (2) begin
        t0 = $time;
        @(regulator_switch_clock);
        chk("chopper half", n[0] ? 9'h1AB : 9'h1E8, 9'(($time - t0) / 4));
      end
      wait_cyc(1);
    end
    send(slio_pkg::OP_WR_DIR, 8'h1F);
    for (n = 15; n < 17; n++) begin
      cs_n <= 1'b1;
      wait_cyc(2);
      cs_n <= 1'b0;
      repeat (n) begin
        host_serial_clock <= 1'b1;
        wait_cyc(2);
        host_serial_clock <= 1'b0;
        wait_cyc(2);
      end
      cs_n <= 1'b1;
      wait_cyc(4);
      chk("line_oe hw reset", n == 15 ? 9'h01F : 9'h000, line_oe[2]);
    end
    cs_n <= 1'b0;
    wait_cyc(10);
    chk("pending reads", 9'h000, 9'(exp_q.size()));
    conclude();
  end
endmodule
